// ### hw/idr_irq_dma_router.sv
// Configuration port and IRQ/DMA routing of the logical devices
`timescale 1ns/1ps
`include "idr_regs.svh"

module idr_irq_dma_router
    import idr_pkg::*;
#(
    parameter int NSLOT = 6
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    // Strap
    input  wire logic             cfg_port_strap,
    // Host I/O access
    input  wire logic [15:0]      io_addr,
    input  wire logic             io_wr,
    input  wire logic             io_rd,
    input  wire logic [7:0]       io_wdata,
    output logic [7:0]            io_rdata,
    output logic                  io_rdata_hit,
    // Logical device requests and base decode status
    input  wire logic [NSLOT-1:0] dev_irq_req,
    input  wire logic [NSLOT-1:0] dev_dma_req,
    input  wire logic [NSLOT-1:0] dev_base_valid,
    // Floppy local state
    input  wire logic             floppy_dma_gate,
    input  wire logic             floppy_powered_down,
    // Parallel port local state
    input  wire logic             pport_irq_gate,
    input  wire logic             pport_ecp_mode,
    input  wire logic [2:0]       ecp_mode_sel,
    input  wire logic             ecp_service_irq_bit,
    input  wire logic             ecp_dma_gate,
    // UART local state
    input  wire logic [3:0]       uart1_irq_enable_reg,
    input  wire logic             uart1_aux_output_two,
    input  wire logic [3:0]       uart2_irq_enable_reg,
    input  wire logic             uart2_aux_output_two,
    // Keyboard and SMBus local state
    input  wire logic             kbd_irq_gate,
    input  wire logic             smbus_irq_gate,
    // System management and serial IRQ mode
    input  wire logic             smi_req,
    input  wire logic             serirq_mode,
    // Routed outputs
    output logic [15:0]           irq_out,
    output logic [3:0]            dma_req_out,
    output logic                  system_mgmt_irq_n,
    output logic [15:0]           serirq_irq_frame
);

    // ----------------------------------------------------------------
    // Configuration state
    // ----------------------------------------------------------------
    logic [15:0]        cfg_base_r,  cfg_base_nxt;
    logic               strap_done_r, strap_done_nxt;
    logic [7:0]         index_r,     index_nxt;
    logic [7:0]         ldn_r,       ldn_nxt;
    logic               irq8_pol_r,  irq8_pol_nxt;
    logic [NSLOT-1:0]   act_r,       act_nxt;
    idr_irq_sel_t       irq_sel_r [NSLOT];
    idr_irq_sel_t       irq_sel_nxt [NSLOT];
    idr_dma_sel_t       dma_sel_r [NSLOT];
    idr_dma_sel_t       dma_sel_nxt [NSLOT];
    logic [7:0]         rdata_nxt;
    logic               rhit_nxt;

    logic               idx_hit;
    logic               dat_hit;
    logic               soft_rst;
    logic               slot_ok;
    logic [2:0]         slot;

    // Index port at base, data at base plus one
    assign idx_hit  = (io_addr == cfg_base_r);
    assign dat_hit  = (io_addr == cfg_base_r + 16'h0001);
    assign soft_rst = io_wr && dat_hit && index_r == `IDR_GREG_SOFT_RST
                      && io_wdata[`IDR_SOFT_RST_BIT];

    // Logical device number to slot
    always_comb begin
        slot_ok = 1'b1;
        slot    = 3'h0;
        if (ldn_r == `IDR_LDN_FLOPPY) begin
            slot = IDR_S_FLOPPY;
        end else if (ldn_r == `IDR_LDN_PPORT) begin
            slot = IDR_S_PPORT;
        end else if (ldn_r == `IDR_LDN_UART1) begin
            slot = IDR_S_UART1;
        end else if (ldn_r == `IDR_LDN_UART2) begin
            slot = IDR_S_UART2;
        end else if (ldn_r == `IDR_LDN_KBD) begin
            slot = IDR_S_KBD;
        end else if (ldn_r == `IDR_LDN_SMBUS) begin
            slot = IDR_S_SMBUS;
        end else begin
            slot_ok = 1'b0;
        end
    end

    always_comb begin
        cfg_base_nxt   = cfg_base_r;
        strap_done_nxt = 1'b1;
        index_nxt      = index_r;
        ldn_nxt        = ldn_r;
        irq8_pol_nxt   = irq8_pol_r;
        act_nxt        = act_r;
        irq_sel_nxt    = irq_sel_r;
        dma_sel_nxt    = dma_sel_r;
        rdata_nxt      = 8'h00;
        rhit_nxt       = 1'b0;
        // Strap caught on the first edge after reset release
        if (!strap_done_r) begin
            cfg_base_nxt = cfg_port_strap ? `IDR_CFG_BASE_STRAP1
                                          : `IDR_CFG_BASE_STRAP0;
        end else if (soft_rst) begin
            act_nxt = '0;
            for (int i = 0; i < NSLOT; i++) begin
                irq_sel_nxt[i] = (i == IDR_S_FLOPPY) ? `IDR_IRQ_SEL_RST_FLOPPY
                                                     : `IDR_IRQ_SEL_RST;
                dma_sel_nxt[i] = (i == IDR_S_FLOPPY) ? `IDR_DMA_SEL_RST_FLOPPY
                                                     : `IDR_DMA_SEL_RST;
            end
        end else if (io_wr && idx_hit) begin
            index_nxt = io_wdata;
        end else if (io_wr && dat_hit) begin
            if (index_r == `IDR_GREG_LDN) begin
                ldn_nxt = io_wdata;
            end else if (index_r == `IDR_GREG_BASE_LO) begin
                cfg_base_nxt[7:0] = io_wdata;
            end else if (index_r == `IDR_GREG_BASE_HI) begin
                cfg_base_nxt[15:8] = io_wdata;
            end else if (index_r == `IDR_REG_OPTION && ldn_r == `IDR_LDN_RUNTIME) begin
                irq8_pol_nxt = io_wdata[`IDR_IRQ8_POL_BIT];
            end else if (slot_ok && index_r == `IDR_REG_ACTIVATE) begin
                act_nxt[slot] = io_wdata[`IDR_ACTIVATE_BIT];
            end else if (slot_ok && index_r == `IDR_REG_IRQ_SEL) begin
                irq_sel_nxt[slot] = io_wdata[3:0];
            end else if (slot_ok && index_r == `IDR_REG_DMA_SEL) begin
                dma_sel_nxt[slot] = io_wdata[2:0];
            end
        end
        // Read answer one cycle after the strobe; reserved bits read zero
        if (io_rd && idx_hit) begin
            rhit_nxt  = 1'b1;
            rdata_nxt = index_r;
        end else if (io_rd && dat_hit) begin
            rhit_nxt = 1'b1;
            if (index_r == `IDR_GREG_LDN) begin
                rdata_nxt = ldn_r;
            end else if (index_r == `IDR_GREG_BASE_LO) begin
                rdata_nxt = cfg_base_r[7:0];
            end else if (index_r == `IDR_GREG_BASE_HI) begin
                rdata_nxt = cfg_base_r[15:8];
            end else if (index_r == `IDR_REG_OPTION && ldn_r == `IDR_LDN_RUNTIME) begin
                rdata_nxt = {7'h00, irq8_pol_r};
            end else if (slot_ok && index_r == `IDR_REG_ACTIVATE) begin
                rdata_nxt = {7'h00, act_r[slot]};
            end else if (slot_ok && index_r == `IDR_REG_IRQ_SEL) begin
                rdata_nxt = {4'h0, irq_sel_r[slot]};
            end else if (slot_ok && index_r == `IDR_REG_DMA_SEL) begin
                rdata_nxt = {5'h00, dma_sel_r[slot]};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_base_r   <= `IDR_CFG_BASE_STRAP0;
            strap_done_r <= 1'b0;
            index_r      <= 8'h00;
            ldn_r        <= 8'h00;
            irq8_pol_r   <= `IDR_IRQ8_POL_RST;
            act_r        <= '0;
            io_rdata     <= 8'h00;
            io_rdata_hit <= 1'b0;
            for (int i = 0; i < NSLOT; i++) begin
                irq_sel_r[i] <= (i == IDR_S_FLOPPY) ? `IDR_IRQ_SEL_RST_FLOPPY
                                                    : `IDR_IRQ_SEL_RST;
                dma_sel_r[i] <= (i == IDR_S_FLOPPY) ? `IDR_DMA_SEL_RST_FLOPPY
                                                    : `IDR_DMA_SEL_RST;
            end
        end else begin
            cfg_base_r   <= cfg_base_nxt;
            strap_done_r <= strap_done_nxt;
            index_r      <= index_nxt;
            ldn_r        <= ldn_nxt;
            irq8_pol_r   <= irq8_pol_nxt;
            act_r        <= act_nxt;
            io_rdata     <= rdata_nxt;
            io_rdata_hit <= rhit_nxt;
            irq_sel_r    <= irq_sel_nxt;
            dma_sel_r    <= dma_sel_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Local enables of each logical device
    // ----------------------------------------------------------------
    logic [NSLOT-1:0] loc_irq_en;
    logic [NSLOT-1:0] loc_dma_en;
    logic             ecp_irq_forced;

    assign ecp_irq_forced = ecp_mode_sel == `IDR_ECP_MODE_FIFO
                         || ecp_mode_sel == `IDR_ECP_MODE_ECP
                         || ecp_mode_sel == `IDR_ECP_MODE_TEST;

    always_comb begin
        loc_irq_en = '0;
        loc_dma_en = '0;
        loc_irq_en[IDR_S_FLOPPY] = floppy_dma_gate && !floppy_powered_down;
        loc_dma_en[IDR_S_FLOPPY] = floppy_dma_gate && !floppy_powered_down;
        if (pport_ecp_mode) begin
            loc_irq_en[IDR_S_PPORT] = (ecp_irq_forced || pport_irq_gate)
                                      && !ecp_service_irq_bit;
            loc_dma_en[IDR_S_PPORT] = ecp_dma_gate;
        end else begin
            loc_irq_en[IDR_S_PPORT] = pport_irq_gate;
        end
        loc_irq_en[IDR_S_UART1] = |uart1_irq_enable_reg && uart1_aux_output_two;
        loc_irq_en[IDR_S_UART2] = |uart2_irq_enable_reg && uart2_aux_output_two;
        loc_irq_en[IDR_S_KBD]   = kbd_irq_gate;
        loc_irq_en[IDR_S_SMBUS] = smbus_irq_gate;
    end

    // ----------------------------------------------------------------
    // Per-slot decode and merge
    // ----------------------------------------------------------------
    logic [15:0] slot_irq [NSLOT];
    logic [3:0]  slot_dma [NSLOT];
    logic [15:0] irq_any;
    logic [3:0]  dma_any;

    for (genvar g = 0; g < NSLOT; g++) begin : g_slot
        idr_route u_route (
            .irq_sel (irq_sel_r[g]),
            .dma_sel (dma_sel_r[g]),
            .irq_req (dev_irq_req[g]),
            .irq_en  (loc_irq_en[g] && act_r[g] && dev_base_valid[g]),
            .dma_req (dev_dma_req[g]),
            .dma_en  (loc_dma_en[g] && act_r[g] && dev_base_valid[g]),
            .irq_vec (slot_irq[g]),
            .dma_vec (slot_dma[g])
        );
    end

    always_comb begin
        irq_any = 16'h0000;
        dma_any = 4'h0;
        for (int i = 0; i < NSLOT; i++) begin
            irq_any = irq_any | slot_irq[i];
            dma_any = dma_any | slot_dma[i];
        end
    end

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    logic [15:0] irq_lvl;
    logic [15:0] irq_out_nxt;
    logic [15:0] frame_nxt;

    always_comb begin
        irq_lvl = irq_any;
        // Level 8 inverted when programmed active low
        irq_lvl[`IDR_IRQ_LINE_POL] = irq_any[`IDR_IRQ_LINE_POL] ^ irq8_pol_r;
        irq_out_nxt = serirq_mode ? 16'h0000 : irq_lvl;
        frame_nxt   = serirq_mode ? irq_lvl : 16'h0000;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_out           <= 16'h0000;
            dma_req_out       <= 4'h0;
            system_mgmt_irq_n <= 1'b1;
            serirq_irq_frame  <= 16'h0000;
        end else begin
            irq_out           <= irq_out_nxt;
            dma_req_out       <= dma_any;
            system_mgmt_irq_n <= !smi_req;
            serirq_irq_frame  <= frame_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence s_idx_wr;
        io_wr && idx_hit && io_wdata == `IDR_REG_IRQ_SEL && !soft_rst;
    endsequence
    sequence s_dat_rd;
        io_rd && dat_hit && slot_ok && !io_wr;
    endsequence

    property p_cfg_read;
        s_idx_wr ##1 s_dat_rd |=> io_rdata_hit && io_rdata == {4'h0, $past(irq_sel_r[slot])};
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("config read mismatch");

    property p_strap;
        $rose(strap_done_r) |-> cfg_base_r == ($past(cfg_port_strap) ? 16'h004E : 16'h002E);
    endproperty
    a_strap: assert property (p_strap) else $error("config base not strapped");

    property p_smi;
        smi_req |=> !system_mgmt_irq_n;
    endproperty
    a_smi: assert property (p_smi) else $error("smi output not low");

    property p_irq8_pol;
        !serirq_mode && irq8_pol_r |=> irq_out[8] == !$past(irq_any[8]);
    endproperty
    a_irq8_pol: assert property (p_irq8_pol) else $error("irq8 polarity wrong");

    property p_soft_irq;
        soft_rst |=> irq_sel_r[0] == 4'h6 && irq_sel_r[1] == 4'h0 && act_r == '0;
    endproperty
    a_soft_irq: assert property (p_soft_irq) else $error("irq select soft reset");

    property p_soft_dma;
        soft_rst |=> dma_sel_r[0] == 3'h2 && dma_sel_r[1] == 3'h4;
    endproperty
    a_soft_dma: assert property (p_soft_dma) else $error("dma select soft reset");

    property p_dma0;
        dma_req_out[0] == 1'b0 && irq_out[0] == 1'b0;
    endproperty
    a_dma0: assert property (p_dma0) else $error("reserved line driven");

    property p_uart_off;
        !uart1_aux_output_two && !uart2_aux_output_two && !act_r[0] && !act_r[1]
            && !act_r[4] && !act_r[5] && !serirq_mode && !irq8_pol_r |=> irq_out == 16'h0000;
    endproperty
    a_uart_off: assert property (p_uart_off) else $error("uart irq not gated");

    property p_serirq;
        serirq_mode |=> irq_out == 16'h0000 && serirq_irq_frame == $past(irq_lvl);
    endproperty
    a_serirq: assert property (p_serirq) else $error("serial irq frame wrong");

    property p_floppy_pd;
        floppy_powered_down && act_r[1:0] == 2'b01 |=> dma_req_out == 4'h0;
    endproperty
    a_floppy_pd: assert property (p_floppy_pd) else $error("floppy dma not gated");

endmodule

// ### hw/idr_pkg.sv
// Types shared by the IRQ/DMA router
package idr_pkg;
    typedef logic [3:0] idr_irq_sel_t;
    typedef logic [2:0] idr_dma_sel_t;

    // Slot order of the logical devices with interrupt and DMA selects
    typedef enum logic [2:0] {
        IDR_S_FLOPPY = 3'h0,
        IDR_S_PPORT  = 3'h1,
        IDR_S_UART1  = 3'h2,
        IDR_S_UART2  = 3'h3,
        IDR_S_KBD    = 3'h4,
        IDR_S_SMBUS  = 3'h5
    } idr_slot_e;
endpackage

// ### hw/idr_regs.svh
// Configuration offsets, field positions and reset values of the IRQ/DMA router
`ifndef IDR_REGS_SVH
`define IDR_REGS_SVH

// ----------------------------------------------------------------
// Configuration port placement
// ----------------------------------------------------------------
`define IDR_CFG_BASE_STRAP0   16'h002E
`define IDR_CFG_BASE_STRAP1   16'h004E

// ----------------------------------------------------------------
// Global configuration register indices
// ----------------------------------------------------------------
`define IDR_GREG_SOFT_RST     8'h02
`define IDR_GREG_LDN          8'h07
`define IDR_GREG_BASE_LO      8'h26
`define IDR_GREG_BASE_HI      8'h27
`define IDR_SOFT_RST_BIT      0

// ----------------------------------------------------------------
// Per logical device register indices
// ----------------------------------------------------------------
`define IDR_REG_ACTIVATE      8'h30
`define IDR_REG_IRQ_SEL       8'h70
`define IDR_REG_DMA_SEL       8'h74
`define IDR_REG_OPTION        8'hF1
`define IDR_ACTIVATE_BIT      0
`define IDR_IRQ8_POL_BIT      0

// ----------------------------------------------------------------
// Logical device numbers
// ----------------------------------------------------------------
`define IDR_LDN_FLOPPY        8'h00
`define IDR_LDN_PPORT         8'h03
`define IDR_LDN_UART1         8'h04
`define IDR_LDN_UART2         8'h05
`define IDR_LDN_KBD           8'h07
`define IDR_LDN_RUNTIME       8'h0A
`define IDR_LDN_SMBUS         8'h0B

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IDR_IRQ_SEL_RST_FLOPPY 4'h6
`define IDR_IRQ_SEL_RST        4'h0
`define IDR_DMA_SEL_RST_FLOPPY 3'h2
`define IDR_DMA_SEL_RST        3'h4
`define IDR_ACTIVATE_RST       1'b0
`define IDR_IRQ8_POL_RST       1'b0

// ----------------------------------------------------------------
// Field encodings
// ----------------------------------------------------------------
`define IDR_IRQ_LINE_POL      8
`define IDR_DMA_MAX           3'h3
`define IDR_ECP_MODE_FIFO     3'h2
`define IDR_ECP_MODE_ECP      3'h3
`define IDR_ECP_MODE_TEST     3'h6

`endif

// ### hw/idr_route.sv
// One logical device's decode of its level and channel selects
`timescale 1ns/1ps
`include "idr_regs.svh"
module idr_route
    import idr_pkg::*;
(
    // Selects
    input  wire idr_irq_sel_t irq_sel,
    input  wire idr_dma_sel_t dma_sel,
    // Request and gating
    input  wire logic         irq_req,
    input  wire logic         irq_en,
    input  wire logic         dma_req,
    input  wire logic         dma_en,
    // Decoded lines
    output logic [15:0]       irq_vec,
    output logic [3:0]        dma_vec
);

    always_comb begin
        irq_vec = 16'h0000;
        // Zero selects nothing, 1..15 picks the line
        if (irq_sel != 4'h0 && irq_en && irq_req) begin
            irq_vec[irq_sel] = 1'b1;
        end
    end

    always_comb begin
        dma_vec = 4'h0;
        // Only 1..3 drive a channel; 0 reserved, 4..7 none
        if (dma_sel != 3'h0 && dma_sel <= `IDR_DMA_MAX && dma_en && dma_req) begin
            dma_vec[dma_sel[1:0]] = 1'b1;
        end
    end

endmodule

// ### sim/idr_host_model.sv
// Host side model issuing configuration port cycles
`timescale 1ns/1ps
module idr_host_model (
    // Clock
    input  wire logic        sys_clk,
    // Host I/O access
    output logic [15:0]      io_addr,
    output logic             io_wr,
    output logic             io_rd,
    output logic [7:0]       io_wdata,
    input  wire logic [7:0]  io_rdata,
    input  wire logic        io_rdata_hit
);
    initial begin
        io_addr  = 16'h0000;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'h00;
    end

    // One write per rising edge; strobe stays up for back-to-back writes
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        io_addr  = a;
        io_wdata = d;
        io_wr    = 1'b1;
        @(negedge sys_clk);
    endtask

    // Drop the write strobe and let one edge pass
    task automatic idle;
        io_wr = 1'b0;
        @(negedge sys_clk);
    endtask

    // Read strobe, then bounded wait for the registered answer
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
        int i;
        ok      = 1'b0;
        d       = 8'h00;
        io_wr   = 1'b0;
        io_addr = a;
        io_rd   = 1'b1;
        @(negedge sys_clk);
        io_rd   = 1'b0;
        for (i = 0; i < 4 && ok !== 1'b1; i++) begin
            if (io_rdata_hit === 1'b1) begin
                ok = 1'b1;
                d  = io_rdata;
            end
            @(negedge sys_clk);
        end
    endtask
endmodule

// ### sim/test_irq_dma_channel_routing.sv
// Self-checking bench of the IRQ/DMA router
`timescale 1ns/1ps
`include "idr_regs.svh"
`define CHK(a, b) chk(16'(a), 16'(b))
module test_irq_dma_channel_routing;
    import idr_pkg::*;
    localparam logic [15:0] B = `IDR_CFG_BASE_STRAP0;
    logic sys_clk = 1'b0, rstn = 1'b0;
    logic [15:0] io_addr, irq_out, serirq_irq_frame;
    logic io_wr, io_rd, io_rdata_hit, system_mgmt_irq_n;
    logic [7:0] io_wdata, io_rdata;
    logic [3:0] dma_req_out, u1_ier = 4'h0;
    logic [5:0] req = 6'h3F;
    logic fgate = 0, fpd = 0, pgate = 0, ecp = 0, svc = 0, edma = 0, u1_o2 = 0;
    logic smb = 0, smi = 0, ser = 0, strap = 0;
    logic [2:0] emode = 3'h0;
    int n_fail = 0, n_tests = 0;

    always #25 sys_clk = ~sys_clk;

    idr_host_model host (.sys_clk(sys_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_hit(io_rdata_hit));

    idr_irq_dma_router #(.NSLOT(6)) uut (.sys_clk(sys_clk), .rstn(rstn), .cfg_port_strap(strap),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_rdata_hit(io_rdata_hit), .dev_irq_req(req),
        .dev_dma_req(req), .dev_base_valid(req), .floppy_dma_gate(fgate),
        .floppy_powered_down(fpd), .pport_irq_gate(pgate), .pport_ecp_mode(ecp),
        .ecp_mode_sel(emode), .ecp_service_irq_bit(svc), .ecp_dma_gate(edma),
        .uart1_irq_enable_reg(u1_ier), .uart1_aux_output_two(u1_o2),
        .uart2_irq_enable_reg(4'h0), .uart2_aux_output_two(1'b0), .kbd_irq_gate(1'b0),
        .smbus_irq_gate(smb), .smi_req(smi), .serirq_mode(ser), .irq_out(irq_out),
        .dma_req_out(dma_req_out), .system_mgmt_irq_n(system_mgmt_irq_n),
        .serirq_irq_frame(serirq_irq_frame));

    task automatic test_done;
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic cfg(input logic [7:0] ldn, input logic [7:0] idx, input logic [7:0] v);
        host.wr(B, 8'h07);
        host.wr(B + 16'h1, ldn);
        host.wr(B, idx);
        host.wr(B + 16'h1, v);
        host.idle();
    endtask

    task automatic cfg_chk(input logic [7:0] ldn, input logic [7:0] idx, input logic [7:0] e);
        logic [7:0] d;
        logic ok;
        host.wr(B, 8'h07);
        host.wr(B + 16'h1, ldn);
        host.wr(B, idx);
        host.rd(B + 16'h1, d, ok);
        if (ok !== 1'b1) begin
            n_fail++;
            test_done();
        end
        `CHK(d, e);
    endtask

    task automatic settle(input logic [15:0] ei, input logic [3:0] ed);
        repeat (2) @(negedge sys_clk);
        `CHK(irq_out, ei);
        `CHK(dma_req_out, ed);
    endtask

    task automatic t_reset;
        cfg_chk(8'h00, 8'h70, 8'h06);
        cfg_chk(8'h00, 8'h74, 8'h02);
        cfg_chk(8'h03, 8'h74, 8'h04);
        cfg_chk(8'h04, 8'h70, 8'h00);
        $display("test reset values finished");
    endtask

    task automatic t_floppy;
        settle(16'h0000, 4'h0);
        cfg(8'h00, 8'h30, 8'h01);
        settle(16'h0000, 4'h0);
        fgate = 1;
        settle(16'h0040, 4'h4);
        fpd = 1;
        settle(16'h0000, 4'h0);
        fpd = 0;
        req[0] = 0;
        settle(16'h0000, 4'h0);
        req[0] = 1;
        cfg(8'h00, 8'h30, 8'h00);
        $display("test floppy finished");
    endtask

    task automatic t_pport;
        cfg(8'h03, 8'h70, 8'h07);
        cfg(8'h03, 8'h74, 8'h01);
        cfg(8'h03, 8'h30, 8'h01);
        ecp = 1;
        edma = 1;
        for (int m = 0; m < 8; m++) begin
            emode = 3'(m);
            settle((m == 2 || m == 3 || m == 6) ? 16'h0080 : 16'h0000, 4'h2);
        end
        emode = 3'h2;
        svc = 1;
        settle(16'h0000, 4'h2);
        edma = 0;
        settle(16'h0000, 4'h0);
        ecp = 0;
        svc = 0;
        pgate = 1;
        settle(16'h0080, 4'h0);
        cfg(8'h03, 8'h30, 8'h00);
        $display("test parallel port finished");
    endtask

    task automatic t_uart;
        cfg(8'h04, 8'h70, 8'h04);
        cfg(8'h04, 8'h30, 8'h01);
        u1_o2 = 1;
        settle(16'h0000, 4'h0);
        u1_ier = 4'h8;
        settle(16'h0010, 4'h0);
        u1_o2 = 0;
        settle(16'h0000, 4'h0);
        $display("test uart finished");
    endtask

    task automatic t_smbus;
        cfg(8'h0B, 8'h70, 8'h0B);
        cfg(8'h0B, 8'h30, 8'h01);
        smb = 1;
        settle(16'h0800, 4'h0);
        ser = 1;
        smi = 1;
        settle(16'h0000, 4'h0);
        `CHK(serirq_irq_frame, 16'h0800);
        `CHK(system_mgmt_irq_n, 16'h0000);
        ser = 0;
        smi = 0;
        smb = 0;
        settle(16'h0000, 4'h0);
        cfg(8'h0B, 8'h70, 8'h02);
        smb = 1;
        settle(16'h0004, 4'h0);
        smb = 0;
        cfg(8'h0A, 8'hF1, 8'h01);
        settle(16'h0100, 4'h0);
        host.wr(B, 8'h02);
        host.wr(B + 16'h1, 8'h01);
        cfg_chk(8'h0B, 8'h70, 8'h00);
        cfg_chk(8'h04, 8'h70, 8'h00);
        cfg_chk(8'h0A, 8'hF1, 8'h01);
        $display("test smbus and soft reset finished");
    endtask

    task automatic t_strap;
        logic [7:0] d;
        logic ok;
        strap = 1'b1;
        smi   = 1'b1;
        rstn  = 1'b0;
        repeat (2) @(negedge sys_clk);
        `CHK(system_mgmt_irq_n, 1'b1);
        `CHK(irq_out, 16'h0000);
        smi  = 1'b0;
        rstn = 1'b1;
        repeat (2) @(negedge sys_clk);
        host.wr(`IDR_CFG_BASE_STRAP1, `IDR_GREG_BASE_LO);
        host.rd(`IDR_CFG_BASE_STRAP1 + 16'h1, d, ok);
        `CHK(ok, 1'b1);
        `CHK(d, 8'h4E);
        host.wr(`IDR_CFG_BASE_STRAP1 + 16'h1, 8'h60);
        host.rd(16'h0060, d, ok);
        `CHK(d, `IDR_GREG_BASE_LO);
        $display("test strap and relocation finished");
    endtask

    initial begin
        repeat (8) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (2) @(negedge sys_clk);
        t_reset();
        t_floppy();
        t_pport();
        t_uart();
        t_smbus();
        t_strap();
        test_done();
    end
endmodule
